// *** core/pnp_busy_timer.sv ***
`timescale 1ns/1ps
module pnp_busy_timer #(
    parameter int unsigned CNT_W = pnp_pkg::TMR_W
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic start,
    input wire logic [CNT_W-1:0] load_val,
    output logic done
);

    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] nxt_cnt;
    logic run_ff;
    logic nxt_run;
    logic done_ff;
    logic nxt_done;

    initial
    begin
        if (CNT_W < 2)
        begin
            $error("pnp_busy_timer: counter too narrow");
        end
    end

    // A load of zero is treated as one so the timer always ends.
    always_comb
    begin
        nxt_cnt = cnt_ff;
        nxt_run = run_ff;
        nxt_done = 1'b0;
        if (start)
        begin
            nxt_cnt = (load_val == '0) ? CNT_W'(1) : load_val;
            nxt_run = 1'b1;
        end
        else if (run_ff)
        begin
            if (cnt_ff == CNT_W'(1))
            begin
                nxt_run = 1'b0;
                nxt_done = 1'b1;
            end
            nxt_cnt = cnt_ff - CNT_W'(1);
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            cnt_ff <= '0;
            run_ff <= 1'b0;
            done_ff <= 1'b0;
        end
        else
        begin
            cnt_ff <= nxt_cnt;
            run_ff <= nxt_run;
            done_ff <= nxt_done;
        end
    end

    assign done = done_ff;

endmodule : pnp_busy_timer

// *** core/pnp_nvm_port.sv ***
`timescale 1ns/1ps
module pnp_nvm_port #(
    parameter int unsigned PAGE_BUSY_CYCLES = pnp_pkg::PAGE_BUSY_CYC,
    parameter int unsigned ERASE_BUSY_CYCLES = pnp_pkg::ERASE_BUSY_CYC,
    parameter int unsigned FLASH_PAGE_WORDS = pnp_pkg::FLASH_PAGE_WORDS,
    parameter int unsigned EE_PAGE_BYTES = pnp_pkg::EE_PAGE_BYTES
) (
    input wire logic CLK,
    input wire logic SRST,
    input wire logic HV_RESET_ACTIVE,
    input wire logic KEEP_NV_DATA_FUSE,
    input wire pnp_pkg::pnp_pins_s PINS,
    output logic PROG_MODE,
    output logic PROG_DONE_FLAG,
    output pnp_pkg::pnp_nvm_req_s NVM_REQ
);

    localparam int unsigned FW = $clog2(FLASH_PAGE_WORDS);
    localparam int unsigned EW = $clog2(EE_PAGE_BYTES);
    localparam int unsigned IDX_W = (FW > EW) ? FW : EW;

    initial
    begin
        if (FLASH_PAGE_WORDS < 2 || FLASH_PAGE_WORDS > 256 ||
            (1 << FW) != FLASH_PAGE_WORDS)
        begin
            $error("pnp_nvm_port: flash page must be a power of two up to 256");
        end
        if (EE_PAGE_BYTES < 2 || EE_PAGE_BYTES > 256 || (1 << EW) != EE_PAGE_BYTES)
        begin
            $error("pnp_nvm_port: EEPROM page must be a power of two up to 256");
        end
        if (PAGE_BUSY_CYCLES < 1 || PAGE_BUSY_CYCLES >= (1 << pnp_pkg::TMR_W) ||
            ERASE_BUSY_CYCLES < 1 || ERASE_BUSY_CYCLES >= (1 << pnp_pkg::TMR_W))
        begin
            $error("pnp_nvm_port: busy count out of timer range");
        end
    end

    // Mode entry and exit.
    logic [pnp_pkg::ENTRY_CNT_W-1:0] entry_cnt_ff;
    logic [pnp_pkg::ENTRY_CNT_W-1:0] nxt_entry_cnt;
    logic prog_mode_ff;
    logic nxt_prog_mode;
    logic [3:0] entry_pins;

    assign entry_pins = {PINS.buffer_latch, PINS.action_hi, PINS.action_lo, PINS.byte_sel_one};

    // The pattern is judged on the last cycle of the hold window, so a
    // programmer that changes it early is simply not admitted.
    always_comb
    begin
        nxt_entry_cnt = entry_cnt_ff;
        nxt_prog_mode = prog_mode_ff;
        if (!HV_RESET_ACTIVE)
        begin
            nxt_entry_cnt = '0;
            nxt_prog_mode = 1'b0;
        end
        else if (entry_cnt_ff < pnp_pkg::ENTRY_CNT_W'(pnp_pkg::ENTRY_HOLD_CYC))
        begin
            nxt_entry_cnt = entry_cnt_ff + pnp_pkg::ENTRY_CNT_W'(1);
            if (entry_cnt_ff == pnp_pkg::ENTRY_CNT_W'(pnp_pkg::ENTRY_HOLD_CYC - 1) &&
                entry_pins == pnp_pkg::ENTRY_PATTERN)
            begin
                nxt_prog_mode = 1'b1;
            end
        end
    end

    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            entry_cnt_ff <= '0;
            prog_mode_ff <= 1'b0;
        end
        else
        begin
            entry_cnt_ff <= nxt_entry_cnt;
            prog_mode_ff <= nxt_prog_mode;
        end
    end

    // Strobe edges.
    logic load_prev_ff;
    logic latch_prev_ff;
    logic wr_prev_ff;
    logic load_rise;
    logic latch_rise;
    logic wr_fall;
    pnp_pkg::pnp_state_e state_ff;
    pnp_pkg::pnp_state_e nxt_state;
    logic accept;

    // Strobes seen while busy are dropped; their effect would be undefined.
    assign accept = prog_mode_ff && (state_ff == pnp_pkg::ST_IDLE);
    assign load_rise = accept && PINS.load_pulse && !load_prev_ff;
    assign latch_rise = accept && PINS.buffer_latch && !latch_prev_ff;
    assign wr_fall = accept && !PINS.write_n && wr_prev_ff;

    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            load_prev_ff <= 1'b0;
            latch_prev_ff <= 1'b0;
            wr_prev_ff <= 1'b1;
        end
        else
        begin
            load_prev_ff <= PINS.load_pulse;
            latch_prev_ff <= PINS.buffer_latch;
            wr_prev_ff <= PINS.write_n;
        end
    end

    // Command, address and data holding registers.
    logic [7:0] cmd_ff;
    logic [7:0] nxt_cmd;
    logic [7:0] addr_lo_ff;
    logic [7:0] nxt_addr_lo;
    logic [7:0] addr_hi_ff;
    logic [7:0] nxt_addr_hi;
    logic [7:0] data_lo_ff;
    logic [7:0] nxt_data_lo;
    logic [7:0] data_hi_ff;
    logic [7:0] nxt_data_hi;
    logic wr_armed_ff;
    logic nxt_wr_armed;

    always_comb
    begin
        nxt_cmd = cmd_ff;
        nxt_addr_lo = addr_lo_ff;
        nxt_addr_hi = addr_hi_ff;
        nxt_data_lo = data_lo_ff;
        nxt_data_hi = data_hi_ff;
        nxt_wr_armed = wr_armed_ff;
        if (!prog_mode_ff)
        begin
            nxt_cmd = pnp_pkg::CMD_RST;
            nxt_wr_armed = 1'b0;
        end
        else if (load_rise)
        begin
            case ({PINS.action_hi, PINS.action_lo})
                pnp_pkg::ACT_CMD:
                begin
                    if (!PINS.byte_sel_one)
                    begin
                        nxt_cmd = PINS.data;
                        nxt_wr_armed = (PINS.data == pnp_pkg::CMD_WRITE_FLASH) ||
                                       (PINS.data == pnp_pkg::CMD_WRITE_EEPROM);
                    end
                end
                pnp_pkg::ACT_ADDR:
                begin
                    if (PINS.byte_sel_one)
                    begin
                        nxt_addr_hi = PINS.data;
                    end
                    else
                    begin
                        nxt_addr_lo = PINS.data;
                    end
                end
                pnp_pkg::ACT_DATA:
                begin
                    if (PINS.byte_sel_one)
                    begin
                        nxt_data_hi = PINS.data;
                    end
                    else
                    begin
                        nxt_data_lo = PINS.data;
                    end
                end
                default:
                begin
                    nxt_cmd = cmd_ff;
                end
            endcase
        end
    end

    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            cmd_ff <= pnp_pkg::CMD_RST;
            addr_lo_ff <= pnp_pkg::BYTE_RST;
            addr_hi_ff <= pnp_pkg::BYTE_RST;
            data_lo_ff <= pnp_pkg::BYTE_RST;
            data_hi_ff <= pnp_pkg::BYTE_RST;
            wr_armed_ff <= 1'b0;
        end
        else
        begin
            cmd_ff <= nxt_cmd;
            addr_lo_ff <= nxt_addr_lo;
            addr_hi_ff <= nxt_addr_hi;
            data_lo_ff <= nxt_data_lo;
            data_hi_ff <= nxt_data_hi;
            wr_armed_ff <= nxt_wr_armed;
        end
    end

    // Page buffers; each holds exactly one page.
    logic [15:0] flash_buf_ff [FLASH_PAGE_WORDS];
    logic [7:0] ee_buf_ff [EE_PAGE_BYTES];
    logic [FW-1:0] flash_word_idx;
    logic [EW-1:0] ee_byte_idx;

    assign flash_word_idx = addr_lo_ff[FW-1:0];
    assign ee_byte_idx = addr_lo_ff[EW-1:0];

    generate
        for (genvar gi = 0; gi < FLASH_PAGE_WORDS; gi++)
        begin : g_flash_buf
            always_ff @(posedge CLK)
            begin
                if (SRST)
                begin
                    flash_buf_ff[gi] <= 16'hFFFF;
                end
                else if (latch_rise && PINS.byte_sel_one && wr_armed_ff &&
                         cmd_ff == pnp_pkg::CMD_WRITE_FLASH && flash_word_idx == FW'(gi))
                begin
                    flash_buf_ff[gi] <= {data_hi_ff, data_lo_ff};
                end
            end
        end
        for (genvar gj = 0; gj < EE_PAGE_BYTES; gj++)
        begin : g_ee_buf
            always_ff @(posedge CLK)
            begin
                if (SRST)
                begin
                    ee_buf_ff[gj] <= 8'hFF;
                end
                else if (latch_rise && wr_armed_ff &&
                         cmd_ff == pnp_pkg::CMD_WRITE_EEPROM && ee_byte_idx == EW'(gj))
                begin
                    ee_buf_ff[gj] <= data_lo_ff;
                end
            end
        end
    endgenerate

    // Sequencer.
    logic [IDX_W-1:0] idx_ff;
    logic [IDX_W-1:0] nxt_idx;
    logic sel_ee_ff;
    logic nxt_sel_ee;
    logic done_flag_ff;
    logic nxt_done_flag;
    logic tmr_start_ff;
    logic nxt_tmr_start;
    logic [pnp_pkg::TMR_W-1:0] tmr_load_ff;
    logic [pnp_pkg::TMR_W-1:0] nxt_tmr_load;
    logic tmr_done;
    pnp_pkg::pnp_nvm_req_s req_ff;
    pnp_pkg::pnp_nvm_req_s nxt_req;
    logic [pnp_pkg::FLASH_ADDR_W-1:0] flash_addr;
    logic [pnp_pkg::EE_ADDR_W-1:0] ee_addr;
    logic last_word;
    logic [15:0] addr_full;

    assign addr_full = {addr_hi_ff, addr_lo_ff};
    assign flash_addr = addr_full[pnp_pkg::FLASH_ADDR_W-1:0];
    assign ee_addr = addr_full[pnp_pkg::EE_ADDR_W-1:0];
    assign last_word = sel_ee_ff ? (idx_ff == IDX_W'(EE_PAGE_BYTES - 1)) :
                                   (idx_ff == IDX_W'(FLASH_PAGE_WORDS - 1));

    // Page words are streamed one per cycle; the busy time is counted only
    // after the stream, which costs a few cycles but keeps one timer.
    always_comb
    begin
        nxt_state = state_ff;
        nxt_idx = idx_ff;
        nxt_sel_ee = sel_ee_ff;
        nxt_tmr_start = 1'b0;
        nxt_tmr_load = tmr_load_ff;
        nxt_req = '0;
        case (state_ff)
            pnp_pkg::ST_IDLE:
            begin
                if (wr_fall && cmd_ff == pnp_pkg::CMD_CHIP_ERASE)
                begin
                    nxt_state = pnp_pkg::ST_ERASE;
                    nxt_req.erase_flash = 1'b1;
                    nxt_req.erase_eeprom = !KEEP_NV_DATA_FUSE;
                    nxt_tmr_start = 1'b1;
                    nxt_tmr_load = pnp_pkg::TMR_W'(ERASE_BUSY_CYCLES);
                end
                else if (wr_fall && wr_armed_ff && cmd_ff == pnp_pkg::CMD_WRITE_FLASH)
                begin
                    nxt_state = pnp_pkg::ST_WRPAGE;
                    nxt_sel_ee = 1'b0;
                    nxt_idx = '0;
                end
                else if (wr_fall && wr_armed_ff && !PINS.byte_sel_one &&
                         cmd_ff == pnp_pkg::CMD_WRITE_EEPROM)
                begin
                    nxt_state = pnp_pkg::ST_WRPAGE;
                    nxt_sel_ee = 1'b1;
                    nxt_idx = '0;
                end
            end
            pnp_pkg::ST_WRPAGE:
            begin
                nxt_req.we = 1'b1;
                nxt_req.sel_eeprom = sel_ee_ff;
                if (sel_ee_ff)
                begin
                    nxt_req.addr = pnp_pkg::FLASH_ADDR_W'({ee_addr[pnp_pkg::EE_ADDR_W-1:EW],
                                                            idx_ff[EW-1:0]});
                    nxt_req.wdata = {8'h00, ee_buf_ff[idx_ff[EW-1:0]]};
                end
                else
                begin
                    nxt_req.addr = {flash_addr[pnp_pkg::FLASH_ADDR_W-1:FW],
                                    idx_ff[FW-1:0]};
                    nxt_req.wdata = flash_buf_ff[idx_ff[FW-1:0]];
                end
                nxt_idx = idx_ff + IDX_W'(1);
                if (last_word)
                begin
                    nxt_state = pnp_pkg::ST_WAIT;
                    nxt_tmr_start = 1'b1;
                    nxt_tmr_load = pnp_pkg::TMR_W'(PAGE_BUSY_CYCLES);
                end
            end
            pnp_pkg::ST_WAIT:
            begin
                if (tmr_done)
                begin
                    nxt_state = pnp_pkg::ST_IDLE;
                end
            end
            pnp_pkg::ST_ERASE:
            begin
                if (tmr_done)
                begin
                    nxt_state = pnp_pkg::ST_LOCK;
                end
            end
            pnp_pkg::ST_LOCK:
            begin
                nxt_req.lock_clear = 1'b1;
                nxt_state = pnp_pkg::ST_IDLE;
            end
            default:
            begin
                nxt_state = pnp_pkg::ST_IDLE;
            end
        endcase
        if (!prog_mode_ff)
        begin
            nxt_state = pnp_pkg::ST_IDLE;
            nxt_req = '0;
            nxt_tmr_start = 1'b0;
        end
        nxt_done_flag = (nxt_state == pnp_pkg::ST_IDLE);
    end

    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            state_ff <= pnp_pkg::ST_IDLE;
            idx_ff <= '0;
            sel_ee_ff <= 1'b0;
            done_flag_ff <= 1'b1;
            tmr_start_ff <= 1'b0;
            tmr_load_ff <= '0;
            req_ff <= '0;
        end
        else
        begin
            state_ff <= nxt_state;
            idx_ff <= nxt_idx;
            sel_ee_ff <= nxt_sel_ee;
            done_flag_ff <= nxt_done_flag;
            tmr_start_ff <= nxt_tmr_start;
            tmr_load_ff <= nxt_tmr_load;
            req_ff <= nxt_req;
        end
    end

    pnp_busy_timer #(
        .CNT_W(pnp_pkg::TMR_W)
    ) u_busy_timer (
        .clk(CLK),
        .srst(SRST),
        .start(tmr_start_ff),
        .load_val(tmr_load_ff),
        .done(tmr_done)
    );

    assign PROG_MODE = prog_mode_ff;
    assign PROG_DONE_FLAG = done_flag_ff;
    assign NVM_REQ = req_ff;

endmodule : pnp_nvm_port

// *** shared/pnp_pkg.sv ***
package pnp_pkg;

    // Clock rate used to turn times into cycle counts.
    localparam int unsigned CLK_MHZ = 200;

    // Least hold time of the entry pattern after high voltage appears.
    localparam int unsigned ENTRY_HOLD_NS = 10000;
    localparam int unsigned ENTRY_HOLD_CYC = (ENTRY_HOLD_NS * CLK_MHZ + 999) / 1000;

    // Least busy times for a page write and for a chip erase.
    localparam int unsigned PAGE_BUSY_NS = 3700000;
    localparam int unsigned PAGE_BUSY_CYC = (PAGE_BUSY_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned ERASE_BUSY_NS = 7500000;
    localparam int unsigned ERASE_BUSY_CYC = (ERASE_BUSY_NS * CLK_MHZ + 999) / 1000;

    localparam int unsigned TMR_W = 21;
    localparam int unsigned ENTRY_CNT_W = 12;

    // Mode-entry pattern on latch, action high, action low, byte select one.
    localparam logic [3:0] ENTRY_PATTERN = 4'h0;

    // Action codes for a load pulse.
    localparam logic [1:0] ACT_ADDR = 2'h0;
    localparam logic [1:0] ACT_DATA = 2'h1;
    localparam logic [1:0] ACT_CMD = 2'h2;
    localparam logic [1:0] ACT_IDLE = 2'h3;

    // Command bytes.
    localparam logic [7:0] CMD_CHIP_ERASE = 8'h80;
    localparam logic [7:0] CMD_WRITE_FLASH = 8'h10;
    localparam logic [7:0] CMD_WRITE_EEPROM = 8'h11;
    localparam logic [7:0] CMD_NOP = 8'h00;

    // Values after reset.
    localparam logic [7:0] CMD_RST = 8'h00;
    localparam logic [7:0] BYTE_RST = 8'h00;

    // Memory geometry.
    localparam int unsigned FLASH_ADDR_W = 12;
    localparam int unsigned EE_ADDR_W = 9;
    localparam int unsigned FLASH_PAGE_WORDS = 32;
    localparam int unsigned EE_PAGE_BYTES = 4;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_WRPAGE = 3'h1,
        ST_WAIT = 3'h3,
        ST_ERASE = 3'h2,
        ST_LOCK = 3'h6
    } pnp_state_e;

    typedef struct packed {
        logic [7:0] data;
        logic action_hi;
        logic action_lo;
        logic byte_sel_one;
        logic byte_sel_two;
        logic buffer_latch;
        logic load_pulse;
        logic write_n;
    } pnp_pins_s;

    typedef struct packed {
        logic we;
        logic sel_eeprom;
        logic [FLASH_ADDR_W-1:0] addr;
        logic [15:0] wdata;
        logic erase_flash;
        logic erase_eeprom;
        logic lock_clear;
    } pnp_nvm_req_s;

endpackage : pnp_pkg

// *** sim/pnp_nvm_port_asserts.sv ***
`timescale 1ns/1ps
module pnp_nvm_port_asserts (
    input wire logic CLK,
    input wire logic SRST,
    input wire logic HV_RESET_ACTIVE,
    input wire logic KEEP_NV_DATA_FUSE,
    input wire pnp_pkg::pnp_pins_s PINS,
    input wire logic PROG_MODE,
    input wire logic PROG_DONE_FLAG,
    input wire pnp_pkg::pnp_nvm_req_s NVM_REQ
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (SRST);

    sequence s_ee_start;
        $rose(NVM_REQ.we) && NVM_REQ.sel_eeprom;
    endsequence
    sequence s_ee_walk;
        NVM_REQ.addr[1:0] == 2'h0 ##1 NVM_REQ.we && NVM_REQ.addr[1:0] == 2'h1
            ##1 NVM_REQ.we && NVM_REQ.addr[1:0] == 2'h2
            ##1 NVM_REQ.we && NVM_REQ.addr[1:0] == 2'h3 ##1 !NVM_REQ.we;
    endsequence
    sequence s_fl_start;
        $rose(NVM_REQ.we) && !NVM_REQ.sel_eeprom;
    endsequence
    sequence s_fl_walk;
        NVM_REQ.addr[4:0] == 5'h00 ##1 NVM_REQ.we && NVM_REQ.addr[4:0] == 5'h01;
    endsequence

    AST_EXIT: assert property (!HV_RESET_ACTIVE |=> !PROG_MODE)
        else $error("mode held after high voltage dropped");
    AST_ERASE_BUSY: assert property (NVM_REQ.erase_flash |-> !PROG_DONE_FLAG)
        else $error("erase issued while ready");
    AST_EE_FUSE: assert property (NVM_REQ.erase_flash |->
        NVM_REQ.erase_eeprom == !$past(KEEP_NV_DATA_FUSE))
        else $error("eeprom erase disagrees with keep fuse");
    AST_EE_WITH_FLASH: assert property (NVM_REQ.erase_eeprom |-> NVM_REQ.erase_flash)
        else $error("eeprom erased outside chip erase");
    AST_LOCK_LATE: assert property (NVM_REQ.erase_flash |=> !NVM_REQ.lock_clear [*8])
        else $error("locks released too early");
    AST_LOCK_DONE: assert property ($rose(NVM_REQ.lock_clear) |-> $rose(PROG_DONE_FLAG))
        else $error("lock release not aligned with ready");
    AST_WE_BUSY: assert property (NVM_REQ.we |-> !PROG_DONE_FLAG && PROG_MODE)
        else $error("page write while ready");
    AST_FLASH_WALK: assert property (s_fl_start |-> s_fl_walk)
        else $error("flash page walk wrong");
    AST_EE_WALK: assert property (s_ee_start |-> s_ee_walk)
        else $error("eeprom page walk wrong");
    AST_FLASH_PAGE: assert property (NVM_REQ.we && !NVM_REQ.sel_eeprom && $past(NVM_REQ.we)
        |-> $stable(NVM_REQ.addr[11:5]))
        else $error("page number moved in a burst");
endmodule : pnp_nvm_port_asserts

bind pnp_nvm_port pnp_nvm_port_asserts u_asserts (.CLK(CLK), .SRST(SRST),
    .HV_RESET_ACTIVE(HV_RESET_ACTIVE), .KEEP_NV_DATA_FUSE(KEEP_NV_DATA_FUSE), .PINS(PINS),
    .PROG_MODE(PROG_MODE), .PROG_DONE_FLAG(PROG_DONE_FLAG), .NVM_REQ(NVM_REQ));

// *** sim/pnp_prog_model.sv ***
`timescale 1ns/1ps
module pnp_prog_model (
    input wire logic clk,
    input wire logic done,
    output pnp_pkg::pnp_pins_s pins
);
    initial
    begin
        pins = '0;
        pins.write_n = 1'b1;
    end

    // Kind 0 is a load, 1 a page latch, 2 a write strobe.
    task automatic pulse(input logic [1:0] act, input logic bs1, input logic [7:0] d,
        input int kind, output logic busy);
        int n;
        @(posedge clk);
        pins.action_hi <= act[1];
        pins.action_lo <= act[0];
        pins.byte_sel_one <= bs1;
        pins.data <= d;
        @(posedge clk);
        pins.load_pulse <= kind == 0;
        pins.buffer_latch <= kind == 1;
        pins.write_n <= kind != 2;
        @(posedge clk);
        pins.load_pulse <= 1'b0;
        pins.buffer_latch <= 1'b0;
        pins.write_n <= 1'b1;
        // Released lines show a changed byte, so a stale sample cannot pass.
        pins.data <= ~d;
        repeat (2) @(negedge clk);
        busy = !done;
        n = 0;
        while (!done && n < 5000)
        begin
            @(negedge clk);
            n++;
        end
        @(negedge clk);
    endtask : pulse
endmodule : pnp_prog_model

// *** sim/tb.sv ***
`timescale 1ns/1ps
module tb;
    logic clk;
    logic srst;
    logic hv;
    logic fuse;
    logic b;
    logic erase_ee;
    logic prog_mode;
    logic done;
    pnp_pkg::pnp_pins_s pins;
    pnp_pkg::pnp_nvm_req_s req;
    int err_count = 0;
    int tests_run = 0;
    int seed = 30135;
    int cyc = 0;
    int fbuf[32];
    int ebuf[4];
    int a_hi = 0;
    int a_lo = 0;
    int d_hi = 0;
    int d_lo = 0;
    int erase_n = 0;
    int lock_n = 0;
    logic [12:0] wa_q[$];
    logic [15:0] wd_q[$];

    // Short busy counts keep the run brief; the entry hold stays at its full length.
    pnp_nvm_port #(.PAGE_BUSY_CYCLES(20), .ERASE_BUSY_CYCLES(40)) uut (.CLK(clk),
        .SRST(srst), .HV_RESET_ACTIVE(hv), .KEEP_NV_DATA_FUSE(fuse), .PINS(pins),
        .PROG_MODE(prog_mode), .PROG_DONE_FLAG(done), .NVM_REQ(req));
    pnp_prog_model prog (.clk(clk), .done(done), .pins(pins));

    task automatic end_sim();
        if (err_count == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : end_sim

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            err_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    function automatic logic [7:0] rnd();
        return 8'($random(seed));
    endfunction : rnd

    task automatic ld(input logic [1:0] act, input logic bs1, input logic [7:0] d);
        prog.pulse(act, bs1, d, 0, b);
        if (act == pnp_pkg::ACT_ADDR && bs1)
            a_hi = d;
        else if (act == pnp_pkg::ACT_ADDR)
            a_lo = d;
        else if (act == pnp_pkg::ACT_DATA && bs1)
            d_hi = d;
        else if (act == pnp_pkg::ACT_DATA)
            d_lo = d;
    endtask : ld

    task automatic latch(input logic ee);
        prog.pulse(pnp_pkg::ACT_IDLE, !ee, 8'h00, 1, b);
        if (ee)
            ebuf[a_lo % 4] = d_lo;
        else
            fbuf[a_lo % 32] = d_hi * 256 + d_lo;
    endtask : latch

    task automatic page_cmp(input logic ee);
        int n;
        int base;
        n = ee ? 4 : 32;
        base = ee ? (a_hi * 256 + a_lo) % 512 / 4 * 4 : (a_hi * 256 + a_lo) % 4096 / 32 * 32;
        check("page_len", 16'(wa_q.size()), 16'(n));
        for (int i = 0; i < n; i++)
        begin
            check("page_addr", {3'h0, wa_q[i]}, 16'(base + i + (ee ? 4096 : 0)));
            check("page_data", wd_q[i], 16'(ee ? ebuf[i] : fbuf[i]));
        end
    endtask : page_cmp

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (req.we)
        begin
            wa_q.push_back({req.sel_eeprom, req.addr});
            wd_q.push_back(req.wdata);
        end
        if (req.erase_flash)
        begin
            erase_n++;
            erase_ee = req.erase_eeprom;
        end
        if (req.lock_clear)
            lock_n++;
        if (cyc == 90000)
        begin
            err_count++;
            end_sim();
        end
    end

    initial
    begin
        srst = 1'b1;
        hv = 1'b0;
        fuse = 1'b0;
        foreach (fbuf[i]) fbuf[i] = 'hFFFF;
        foreach (ebuf[i]) ebuf[i] = 'hFF;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        @(negedge clk);
        check("done_rst", done, 16'h1);
        check("mode_rst", prog_mode, 16'h0);
        // Action bits 01 are left on the pins, which spoils the first entry try.
        prog.pulse(pnp_pkg::ACT_DATA, 1'b0, 8'h00, 0, b);
        for (int k = 0; k < 2; k++)
        begin
            @(posedge clk);
            hv <= 1'b1;
            repeat (1996) @(posedge clk);
            @(negedge clk);
            check("mode_early", prog_mode, 16'h0);
            repeat (6) @(negedge clk);
            check("mode_entry", prog_mode, {15'h0, k == 1});
            if (k == 0)
            begin
                @(posedge clk);
                hv <= 1'b0;
                prog.pulse(pnp_pkg::ACT_ADDR, 1'b0, 8'h00, 0, b);
            end
        end
        repeat (58000) @(posedge clk);
        for (int f = 0; f < 2; f++)
        begin
            @(posedge clk);
            fuse <= f[0];
            if (f == 0)
                ld(pnp_pkg::ACT_CMD, 1'b0, pnp_pkg::CMD_CHIP_ERASE);
            erase_n = 0;
            lock_n = 0;
            prog.pulse(pnp_pkg::ACT_IDLE, 1'b0, 8'h00, 2, b);
            check("erase_busy", b, 16'h1);
            check("erase_count", 16'(erase_n), 16'h1);
            check("erase_eeprom", erase_ee, !f[0]);
            check("lock_clear", 16'(lock_n), 16'h1);
        end
        for (int m = 0; m < 3; m++)
        begin
            if (m != 1)
                ld(pnp_pkg::ACT_CMD, 1'b0, m == 2 ? pnp_pkg::CMD_WRITE_EEPROM :
                    pnp_pkg::CMD_WRITE_FLASH);
            ld(pnp_pkg::ACT_ADDR, 1'b1, rnd());
            for (int k = 0; k < (m == 2 ? 4 : 6); k++)
            begin
                ld(pnp_pkg::ACT_ADDR, 1'b0, rnd());
                ld(pnp_pkg::ACT_DATA, 1'b0, rnd());
                ld(pnp_pkg::ACT_DATA, 1'b1, rnd());
                if (m != 2 || d_lo != 'hFF) latch(m == 2);
            end
            wa_q.delete();
            wd_q.delete();
            prog.pulse(pnp_pkg::ACT_IDLE, 1'b0, 8'h00, 2, b);
            check("page_busy", b, 16'h1);
            page_cmp(m == 2);
        end
        ld(pnp_pkg::ACT_CMD, 1'b0, pnp_pkg::CMD_NOP);
        wa_q.delete();
        prog.pulse(pnp_pkg::ACT_IDLE, 1'b0, 8'h00, 2, b);
        check("nop_busy", b, 16'h0);
        check("nop_writes", 16'(wa_q.size()), 16'h0);
        @(posedge clk);
        hv <= 1'b0;
        repeat (2) @(negedge clk);
        check("mode_exit", prog_mode, 16'h0);
        end_sim();
    end
endmodule : tb
